// ==== bench/reset_source_controller_test.sv ====
// self-checking bench of the reset source controller
`timescale 1ns/1ns
`default_nettype none
`include "rsc_cfg.svh"
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_mismatch++; $display("FAIL %0t mismatch", $time); end end
module reset_source_controller_test;
    localparam logic [11:0] A_FLG = {`RSC_FLAGS_IDX, 2'b00};
    localparam logic [11:0] A_WDT = {`RSC_WDT_IDX, 2'b00};
    localparam logic [11:0] A_SUP = {`RSC_SUPPLY_IDX, 2'b00};
    logic pclk, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, monitored_clk, comparator_out, supply_ok, ext_reset_pin_n;
    logic wdt_kick_in = 1'b0, fw = 1'b0, fr = 1'b0, fe = 1'b0, ares = 1'b0, fwe = 1'b0, sblk = 1'b0;
    logic sys_reset_out, pin_drive_oe, pin_drive_out;
    logic clk_run = 1'b1, cmp_low = 1'b0, sup_low = 1'b0, pin_low = 1'b0, kick_on = 1'b1;
    logic [5:0] kcnt = 6'h00;
    logic [32:0] expq[$];
    int n_mismatch = 0, checks = 0;

    rsc_ctrl #(.WDT_TICKS(16)) i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .monitored_clk, .comparator_out, .supply_ok, .ext_reset_pin_n, .wdt_kick_in,
        .flash_write_req(fw), .flash_read_req(fr), .fetch_req(fe), .addr_reserved(ares),
        .flash_write_enable(fwe), .security_blocked(sblk), .sys_reset_out, .pin_drive_oe, .pin_drive_out);
    rsc_partner i_partner (.clk_run, .cmp_low, .sup_low, .pin_low, .pin_drive_oe, .pin_drive_out, .monitored_clk,
        .comparator_out, .supply_ok, .ext_reset_pin_n);

    initial
    begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    // kicks well inside the shortened watchdog span unless a scenario stops them
    always @(posedge pclk)
    begin
        kcnt <= kcnt + 6'h01;
        wdt_kick_in <= kick_on && kcnt == 6'h00;
    end

    always @(posedge pclk)
    begin
        if (psel && penable && pready && expq.size() > 0)
        begin
            if (pwrite)
                `CHK(pslverr, expq[0][32])
            else
                `CHK({pslverr, prdata}, expq[0])
            void'(expq.pop_front());
        end
    end

    task automatic wrap_up;
        if (n_mismatch == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d, input logic [32:0] e);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'($urandom()), d};
        expq.push_back(e);
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic quiet(input int n);
        repeat (n) @(posedge pclk);
        `CHK(sys_reset_out, 1'b0)
    endtask

    task automatic expect_reset(input logic [7:0] fl);
        int n;
        n = 0;
        while (sys_reset_out !== 1'b1 && n < 2000)
        begin
            @(posedge pclk);
            n++;
        end
        repeat (2) @(posedge pclk);
        `CHK(sys_reset_out, 1'b1)
        `CHK(pin_drive_oe, fl == 8'h02)
        `CHK(pin_drive_out, 1'b0)
        clk_run <= 1'b1;
        cmp_low <= 1'b0;
        sup_low <= 1'b0;
        pin_low <= 1'b0;
        kick_on <= 1'b1;
        n = 0;
        while (sys_reset_out !== 1'b0 && n < 2000)
        begin
            @(posedge pclk);
            n++;
        end
        `CHK(sys_reset_out, 1'b0)
        apb(1'b0, A_FLG, 8'h00, {25'h0, fl});
    endtask

    // k: 0 write, 1 read, 2 fetch above reserved space; 3 secured read; 4 and 5 plain reads
    task automatic flash(input int k);
        fwe <= k == 0;
        ares <= k < 3;
        sblk <= k == 3;
        fw <= k == 0;
        fr <= k == 1 || k >= 3;
        fe <= k == 2;
        @(posedge pclk);
        fw <= 1'b0;
        fr <= 1'b0;
        fe <= 1'b0;
        @(posedge pclk);
    endtask

    initial
    begin
        #100000;
        n_mismatch++;
        wrap_up;
    end

    initial
    begin
        int i;
        i = $urandom(74595);
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        expect_reset(8'h02);
        apb(1'b0, 12'($urandom() % 16 * 4), 8'h00, {1'b1, 32'h0});
        apb(1'b1, A_FLG, 8'h10, 33'h0);
        expect_reset(8'h10);
        apb(1'b0, A_WDT, 8'h00, 33'h01);
        kick_on <= 1'b0;
        expect_reset(8'h08);
        apb(1'b1, A_FLG, 8'h00, 33'h0);
        clk_run <= 1'b0;
        quiet(300);
        clk_run <= 1'b1;
        apb(1'b1, A_FLG, 8'h04, 33'h0);
        quiet(200);
        clk_run <= 1'b0;
        expect_reset(8'h04);
        apb(1'b1, A_FLG, 8'h20, 33'h0);
        quiet(10 + $urandom() % 20);
        cmp_low <= 1'b1;
        expect_reset(8'h20);
        flash(4);
        expect_reset(8'h40);
        apb(1'b1, A_SUP, 8'ha0, 33'h0);
        apb(1'b0, A_SUP, 8'h00, 33'he0);
        apb(1'b1, A_FLG, 8'h02, 33'h0);
        flash(5);
        quiet(10);
        for (i = 0; i < 4; i++)
        begin
            flash(i);
            expect_reset(8'h40);
        end
        sup_low <= 1'b1;
        expect_reset(8'h02);
        pin_low <= 1'b1;
        expect_reset(8'h01);
        wrap_up;
    end
endmodule // reset_source_controller_test
`default_nettype wire

// ==== bench/rsc_partner.sv ====
// far-side model: watched clock, comparator 0, supply monitor and reset pin levels
`timescale 1ns/1ns
`default_nettype none
module rsc_partner (
    input wire logic clk_run,     // watched clock toggles while high
    input wire logic cmp_low,     // inverting input above non-inverting input
    input wire logic sup_low,     // supply at or below threshold
    input wire logic pin_low,     // outside circuit pulls the reset pin
    input wire logic pin_drive_oe,  // block pulls the reset pin
    input wire logic pin_drive_out, // level the block drives while pulling
    output logic monitored_clk,   // watched clock, stands still when stopped
    output logic comparator_out,  // comparator 0 output
    output logic supply_ok,       // supply monitor output
    output logic ext_reset_pin_n  // reset pin level, pulled up when idle
);
    // half period unrelated to the system clock so edges drift across it
    initial
    begin
        monitored_clk = 1'b0;
        forever
        begin
            #11;
            if (clk_run)
                monitored_clk = ~monitored_clk;
        end
    end
    // output is high and settled from time zero, so selecting it never catches start-up chatter
    assign comparator_out = ~cmp_low;
    assign supply_ok = ~sup_low;
    // pulled up unless the outside circuit or the block itself pulls it low
    assign ext_reset_pin_n = ~(pin_low || (pin_drive_oe && !pin_drive_out));
endmodule // rsc_partner
`default_nettype wire

// ==== common/rsc_cfg.svh ====
// register map, field positions, reset values and timing counts of the reset source controller
`ifndef RSC_CFG_SVH
`define RSC_CFG_SVH

`define RSC_FLAGS_IDX 10'h0ef
`define RSC_WDT_IDX 10'h0f0
`define RSC_SUPPLY_IDX 10'h0ff

`define RSC_BIT_PIN 0
`define RSC_BIT_POR 1
`define RSC_BIT_MCD 2
`define RSC_BIT_WDT 3
`define RSC_BIT_SW 4
`define RSC_BIT_CMP 5
`define RSC_BIT_FLASH 6

`define RSC_SUP_BIT_EN 7
`define RSC_SUP_BIT_STAT 6
`define RSC_SUP_BIT_LVL 5

`define RSC_WDT_BIT_EN 0
`define RSC_WDT_BIT_KICK 1

`define RSC_FLAGS_RST 8'h02
`define RSC_HOLD_RST 8'hff

`define RSC_CLK_PERIOD_NS 4
`define RSC_MCD_TIMEOUT_NS 500
`define RSC_MCD_CYC ((`RSC_MCD_TIMEOUT_NS + `RSC_CLK_PERIOD_NS - 1) / `RSC_CLK_PERIOD_NS)
`define RSC_RST_HOLD_NS 100
`define RSC_RST_HOLD_CYC ((`RSC_RST_HOLD_NS + `RSC_CLK_PERIOD_NS - 1) / `RSC_CLK_PERIOD_NS)
`define RSC_WDT_DIV 12
`define RSC_WDT_TICKS 65536

`endif

// ==== common/rsc_pkg.sv ====
// types shared by the reset source controller
package rsc_pkg;

    typedef enum logic {RSC_RUN, RSC_HOLD} rsc_phase_t;

    typedef struct packed {
        rsc_phase_t phase;
        logic [7:0] hold_cnt;
        logic [7:0] flags;
        logic mcd_en;
        logic cmp_sel;
        logic por_sel;
        logic sup_en;
        logic sup_lvl;
        logic wdt_en;
        logic wdt_kick;
        logic sw_req;
        logic mcd_last;
        logic [3:0] div_cnt;
        logic div_tick;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic sys_reset;
        logic pin_oe;
        logic pin_out;
    } rsc_state_t;

endpackage

// ==== hw/rsc_ctrl.sv ====
// reset source controller: collects reset requests, records the cause, apb register access
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "rsc_cfg.svh"

module rsc_ctrl
    import rsc_pkg::*;
#(
    parameter int WDT_TICKS = `RSC_WDT_TICKS
) (
    input wire logic pclk,              // system clock
    input wire logic presetn,           // power-on reset, async, active low
    input wire logic psel,              // apb select
    input wire logic penable,           // apb enable
    input wire logic pwrite,            // apb direction
    input wire logic [11:0] paddr,      // apb byte address
    input wire logic [31:0] pwdata,     // apb write data
    output logic [31:0] prdata,         // apb read data
    output logic pready,                // apb ready
    output logic pslverr,               // apb error, unmapped address
    input wire logic monitored_clk,     // clock watched for loss
    input wire logic comparator_out,    // comparator 0 output, async
    input wire logic supply_ok,         // supply above threshold, async
    input wire logic ext_reset_pin_n,   // reset pin level, async
    input wire logic wdt_kick_in,       // watchdog restart from counter array logic
    input wire logic flash_write_req,   // flash write or erase, one cycle
    input wire logic flash_read_req,    // code space data read, one cycle
    input wire logic fetch_req,         // instruction fetch or branch, one cycle
    input wire logic addr_reserved,     // access target at or above reserved space
    input wire logic flash_write_enable,// flash writes enabled
    input wire logic security_blocked,  // access refused by security setting
    output logic sys_reset_out,         // system reset, active high
    output logic pin_drive_oe,          // reset pin pull-down enable
    output logic pin_drive_out          // reset pin driven level
);
    rsc_state_t s;
    rsc_state_t next_s;

    logic cmp_sync;
    logic sup_sync;
    logic pin_sync;
    logic clk_sync;
    logic mcd_exp;
    logic wdt_exp;
    logic flash_any;
    logic flash_err;
    logic [7:0] cause;
    logic [7:0] pick;
    logic setup;
    logic wr_done;
    logic hit_flags;
    logic hit_wdt;
    logic hit_sup;

    rsc_sync2 #(.RST_VAL(1'b1)) u_sync_cmp (.clk(pclk), .rst_n(presetn), .async_in(comparator_out),
        .sync_out(cmp_sync));
    rsc_sync2 #(.RST_VAL(1'b1)) u_sync_sup (.clk(pclk), .rst_n(presetn), .async_in(supply_ok),
        .sync_out(sup_sync));
    rsc_sync2 #(.RST_VAL(1'b1)) u_sync_pin (.clk(pclk), .rst_n(presetn), .async_in(ext_reset_pin_n),
        .sync_out(pin_sync));
    rsc_sync2 #(.RST_VAL(1'b0)) u_sync_clk (.clk(pclk), .rst_n(presetn), .async_in(monitored_clk),
        .sync_out(clk_sync));

    // each edge of the watched clock retriggers the one-shot
    rsc_timeout #(.W(8), .LIMIT(`RSC_MCD_CYC)) u_mcd (
        .clk(pclk),
        .rst_n(presetn),
        .enable(s.mcd_en && !s.sys_reset),
        .tick(1'b1),
        .restart(clk_sync ^ s.mcd_last),
        .expired(mcd_exp)
    );

    rsc_timeout #(.W(17), .LIMIT(WDT_TICKS)) u_wdt (
        .clk(pclk),
        .rst_n(presetn),
        .enable(s.wdt_en && !s.sys_reset),
        .tick(s.div_tick),
        .restart(s.wdt_kick || wdt_kick_in),
        .expired(wdt_exp)
    );

    assign setup = psel && !penable;
    assign wr_done = psel && penable && s.pready && pwrite && !s.pslverr;
    assign hit_flags = (paddr[11:2] == `RSC_FLAGS_IDX) && (paddr[1:0] == 2'b00);
    assign hit_wdt = (paddr[11:2] == `RSC_WDT_IDX) && (paddr[1:0] == 2'b00);
    assign hit_sup = (paddr[11:2] == `RSC_SUPPLY_IDX) && (paddr[1:0] == 2'b00);

    assign flash_any = flash_write_req || flash_read_req;
    assign flash_err = (flash_write_req && flash_write_enable && addr_reserved)
        || ((flash_read_req || fetch_req) && addr_reserved)
        || (flash_any && security_blocked)
        || (flash_any && !(s.sup_lvl && s.sup_en && s.por_sel));

    always_comb
    begin
        cause = 8'h00;
        cause[`RSC_BIT_PIN] = !pin_sync;
        cause[`RSC_BIT_POR] = s.por_sel && s.sup_en && !sup_sync;
        cause[`RSC_BIT_MCD] = mcd_exp;
        cause[`RSC_BIT_WDT] = wdt_exp;
        cause[`RSC_BIT_SW] = s.sw_req;
        cause[`RSC_BIT_CMP] = s.cmp_sel && !cmp_sync;
        cause[`RSC_BIT_FLASH] = flash_err;
        // lowest bit wins so exactly one source is recorded
        pick = 8'h00;
        for (int i = 6; i >= 0; i--)
        begin
            if (cause[i])
            begin
                pick = 8'h00;
                pick[i] = 1'b1;
            end
        end
    end

    always_comb
    begin
        next_s = s;
        next_s.wdt_kick = 1'b0;
        next_s.div_tick = 1'b0;
        next_s.pready = 1'b0;
        next_s.pslverr = 1'b0;
        next_s.mcd_last = clk_sync;
        next_s.pin_out = 1'b0;
        // divide by 12 for the watchdog count enable
        if (s.div_cnt == 4'(`RSC_WDT_DIV - 1))
        begin
            next_s.div_cnt = 4'h0;
            next_s.div_tick = 1'b1;
        end
        else
        begin
            next_s.div_cnt = s.div_cnt + 4'h1;
        end

        // answer is registered in the setup cycle, so every access has one access cycle
        if (setup)
        begin
            next_s.pready = 1'b1;
            next_s.prdata = 32'h0000_0000;
            if (hit_flags)
            begin
                next_s.prdata[6:0] = s.flags[6:0];
            end
            else if (hit_wdt)
            begin
                next_s.prdata[`RSC_WDT_BIT_EN] = s.wdt_en;
            end
            else if (hit_sup)
            begin
                next_s.prdata[`RSC_SUP_BIT_EN] = s.sup_en;
                next_s.prdata[`RSC_SUP_BIT_STAT] = sup_sync;
                next_s.prdata[`RSC_SUP_BIT_LVL] = s.sup_lvl;
            end
            else
            begin
                next_s.pslverr = 1'b1;
            end
        end

        // flag bits read back the cause; written they act as enables and commands
        if (wr_done && hit_flags)
        begin
            next_s.por_sel = pwdata[`RSC_BIT_POR];
            next_s.mcd_en = pwdata[`RSC_BIT_MCD];
            next_s.cmp_sel = pwdata[`RSC_BIT_CMP];
            if (pwdata[`RSC_BIT_SW])
            begin
                next_s.sw_req = 1'b1;
            end
        end
        if (wr_done && hit_wdt)
        begin
            next_s.wdt_en = pwdata[`RSC_WDT_BIT_EN];
            next_s.wdt_kick = pwdata[`RSC_WDT_BIT_KICK];
        end
        if (wr_done && hit_sup)
        begin
            next_s.sup_en = pwdata[`RSC_SUP_BIT_EN];
            next_s.sup_lvl = pwdata[`RSC_SUP_BIT_LVL];
        end

        case (s.phase)
            RSC_RUN:
            begin
                if (|cause)
                begin
                    next_s.phase = RSC_HOLD;
                    next_s.hold_cnt = 8'(`RSC_RST_HOLD_CYC - 1);
                    next_s.flags = pick;
                    next_s.sys_reset = 1'b1;
                    next_s.pin_oe = pick[`RSC_BIT_POR];
                    next_s.mcd_en = 1'b0;
                    next_s.cmp_sel = 1'b0;
                    next_s.wdt_en = 1'b1;
                    next_s.sw_req = 1'b0;
                    next_s.div_cnt = 4'h0;
                    if (pick[`RSC_BIT_POR])
                    begin
                        next_s.por_sel = 1'b0;
                        next_s.sup_lvl = 1'b0;
                    end
                end
            end
            RSC_HOLD:
            begin
                next_s.sw_req = 1'b0;
                if (s.hold_cnt != 8'h00)
                begin
                    next_s.hold_cnt = s.hold_cnt - 8'h01;
                end
                else if (s.pin_oe)
                begin
                    // let go of our own pull-down first, else we would wait on a pin we hold low
                    next_s.pin_oe = 1'b0;
                end
                else if (pin_sync)
                begin
                    next_s.phase = RSC_RUN;
                    next_s.sys_reset = 1'b0;
                end
            end
            default:
            begin
                next_s.phase = RSC_HOLD;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s <= '0;
            s.phase <= RSC_HOLD;
            s.hold_cnt <= `RSC_HOLD_RST;
            s.flags <= `RSC_FLAGS_RST;
            s.wdt_en <= 1'b1;
            s.sys_reset <= 1'b1;
            s.pin_oe <= 1'b1;
        end
        else
        begin
            s <= next_s;
        end
    end

    assign prdata = s.prdata;
    assign pready = s.pready;
    assign pslverr = s.pslverr;
    assign sys_reset_out = s.sys_reset;
    assign pin_drive_oe = s.pin_oe;
    assign pin_drive_out = s.pin_out;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    AST_MCD_FLAG: assert property ($rose(sys_reset_out) && s.flags[`RSC_BIT_MCD] |-> $past(mcd_exp))
        else $error("clock loss flag without expiry");
    AST_MCD_ENABLE: assert property (wr_done && hit_flags && s.phase == RSC_RUN && !(|cause)
        |=> s.mcd_en == $past(pwdata[`RSC_BIT_MCD]))
        else $error("clock loss enable not written");
    AST_PIN_QUIET: assert property (pin_drive_oe |-> s.flags[`RSC_BIT_POR])
        else $error("reset pin driven by internal source");
    AST_CMP_RESET: assert property (s.phase == RSC_RUN && s.cmp_sel && !cmp_sync |=> sys_reset_out)
        else $error("comparator low did not reset");
    AST_WDT_AFTER: assert property ($fell(sys_reset_out) |-> s.wdt_en)
        else $error("watchdog not enabled after reset");
    AST_WDT_FLAG: assert property ($rose(sys_reset_out) && s.flags[`RSC_BIT_WDT] |-> $past(wdt_exp))
        else $error("watchdog flag without overflow");
    AST_FLASH_SEC: assert property (s.phase == RSC_RUN && flash_any && security_blocked |=> sys_reset_out)
        else $error("blocked flash access did not reset");
    AST_SW_FORCE: assert property (wr_done && hit_flags && pwdata[`RSC_BIT_SW] && s.phase == RSC_RUN
        && !(|cause) |-> ##2 sys_reset_out)
        else $error("software force did not reset");
    AST_ONE_CAUSE: assert property ($rose(sys_reset_out) |-> $onehot(s.flags))
        else $error("reset cause not one-hot");
    AST_HOLD_MIN: assert property ($rose(sys_reset_out) |-> sys_reset_out [*8])
        else $error("system reset too short");

    COV_MCD: cover property ($rose(sys_reset_out) && s.flags[`RSC_BIT_MCD]);
    COV_SW: cover property ($rose(sys_reset_out) && s.flags[`RSC_BIT_SW]);
    COV_FLASH: cover property ($rose(sys_reset_out) && s.flags[`RSC_BIT_FLASH]);
    COV_RELEASE: cover property ($fell(sys_reset_out));
endmodule // rsc_ctrl
`default_nettype wire

// ==== hw/rsc_sync2.sv ====
// two-flop synchroniser for one asynchronous level
`timescale 1ns/1ns
`default_nettype none
module rsc_sync2 #(
    parameter logic RST_VAL = 1'b1
) (
    input wire logic clk,       // sampling clock
    input wire logic rst_n,     // async reset, active low
    input wire logic async_in,  // level from another domain
    output logic sync_out       // synchronised level
);
    typedef struct packed {
        logic meta;
        logic stable;
    } rsc_sync_state_t;

    rsc_sync_state_t s;
    rsc_sync_state_t next_s;

    always_comb
    begin
        next_s.meta = async_in;
        next_s.stable = s.meta;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s <= {RST_VAL, RST_VAL};
        end
        else
        begin
            s <= next_s;
        end
    end

    assign sync_out = s.stable;
endmodule // rsc_sync2
`default_nettype wire

// ==== hw/rsc_timeout.sv ====
// tick counter that flags expiry unless restarted; serves clock loss and watchdog
`timescale 1ns/1ns
`default_nettype none
module rsc_timeout #(
    parameter int W = 17,
    parameter int LIMIT = 65536
) (
    input wire logic clk,      // clock
    input wire logic rst_n,    // async reset, active low
    input wire logic enable,   // count only while high
    input wire logic tick,     // one-cycle count enable
    input wire logic restart,  // clears count and expiry
    output logic expired       // level, held until restart or disable
);
    typedef struct packed {
        logic [W-1:0] cnt;
        logic expired;
    } rsc_timeout_state_t;

    rsc_timeout_state_t s;
    rsc_timeout_state_t next_s;

    always_comb
    begin
        next_s = s;
        if (!enable || restart)
        begin
            next_s.cnt = '0;
            next_s.expired = 1'b0;
        end
        else if (tick && !s.expired)
        begin
            if (s.cnt == W'(LIMIT - 1))
            begin
                next_s.expired = 1'b1;
            end
            else
            begin
                next_s.cnt = s.cnt + W'(1);
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s <= '0;
        end
        else
        begin
            s <= next_s;
        end
    end

    assign expired = s.expired;
endmodule // rsc_timeout
`default_nettype wire
